// >>> logic/event_fifo.sv
`timescale 1ns/10ps
module event_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == LAST) ? '0 : p + 1'b1;
   endfunction : bump

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop) rd_ptr <= bump(rd_ptr);
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end

   a_no_overflow: assert property (@(posedge clk) disable iff (rst)
      !in_ready |=> count == FULL_COUNT || $past(pop))
      else $error("fifo count moved while full without a pop");
endmodule : event_fifo

// >>> logic/trig_pkg.sv
// Overview of operation
// - sixteen hit inputs feed both the hit pattern pipeline and the condition logic.
// - eight test bits each force a pair of hit inputs active together.
// - eight conditions settle within 20 ns, stored with hits at next active edge.
// - programmable 8-bit mask enables each trigger condition individually.
// - trigger output is the OR of the masked trigger pattern.
// - timing counter of 5 ns steps starts on first condition, stops at edge.
// - 6-bit timing code pipeline array is one stage shallower; tdc_code, which captures the counter, is the extra stage in front of it.
// - pattern pipeline is four bytes wide, one byte a dummy.
// - six readable bytes: board id, four pattern bytes, one timing byte.
// - bytes selected by 9-bit backplane address, returned on 8-bit data bus.
// - test bits come from the controller's test bit configuration register.
// - pipelines shift each active edge while enabled, step on read-out strobes when enable drops.
package trig_pkg;
   localparam int NUM_HITS = 16;
   localparam int NUM_COND = 8;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 9;
   localparam int TDC_W = 6;
   localparam int PAT_W = 4 * BYTE_W;
   localparam int NUM_LOC = 6;
   // byte locations relative to the board base address
   localparam logic [ADDR_W-1:0] LOC_ID = 9'h000;
   localparam logic [ADDR_W-1:0] LOC_HIT_LO = 9'h001;
   localparam logic [ADDR_W-1:0] LOC_HIT_HI = 9'h002;
   localparam logic [ADDR_W-1:0] LOC_TRIG = 9'h003;
   localparam logic [ADDR_W-1:0] LOC_DUMMY = 9'h004;
   localparam logic [ADDR_W-1:0] LOC_TDC = 9'h005;
   // pattern word fields
   localparam int HIT_LSB = 0;
   localparam int TRIG_LSB = 16;
   localparam int DUMMY_LSB = 24;
   localparam logic [BYTE_W-1:0] DUMMY_BYTE = 8'h00;
   localparam logic [TDC_W-1:0] TDC_MAX = 6'h3f;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int EVAL_NS = 20;
   localparam int EVAL_CYCLES = (EVAL_NS / CLK_PERIOD_NS) < 1 ? 1 : EVAL_NS / CLK_PERIOD_NS;
   localparam int TDC_RES_NS = 5;
   localparam logic [TDC_W-1:0] TDC_STEP = TDC_W'(CLK_PERIOD_NS / TDC_RES_NS);
endpackage : trig_pkg

// >>> logic/trigger_pipeline.sv
`timescale 1ns/10ps
module trigger_pipeline
   import trig_pkg::*;
#(
   parameter int PIPE_DEPTH = 39,
   parameter int TICK_DIV = 10,
   parameter int FIFO_DEPTH = 8,
   parameter logic [ADDR_W-1:0] BOARD_BASE = 9'h100,
   // identification value is arbitrary
   parameter logic [BYTE_W-1:0] BOARD_ID = 8'h5a
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // detector hits and configuration
   input wire logic [NUM_HITS-1:0] HIT_IN,
   input wire logic [NUM_COND-1:0] TEST_BITS,
   input wire logic [NUM_COND-1:0] TRIG_MASK,
   // pipeline control
   input wire logic PIPELINE_SHIFT_ENABLE,
   input wire logic READOUT_SHIFT_STROBE,
   // trigger result
   output logic TRIGGER_OUT,
   // backplane read request
   input wire logic [ADDR_W-1:0] BP_ADDR,
   input wire logic BP_RD_VALID,
   output logic BP_RD_READY,
   // backplane read data
   output logic [BYTE_W-1:0] BP_DATA_OUT,
   output logic BP_DATA_OE,
   output logic BP_DATA_VALID,
   input wire logic BP_DATA_ACK
);
   localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   // test bit i stands for hit inputs 2i and 2i+1
   function automatic logic [NUM_HITS-1:0] expand_tests(input logic [NUM_COND-1:0] t);
      logic [NUM_HITS-1:0] r;
      r = '0;
      for (int i = 0; i < NUM_COND; i++) begin
         r[2*i] = t[i];
         r[2*i+1] = t[i];
      end
      return r;
   endfunction : expand_tests

   // firmware conditions: pair coincidences, even pairs in the low half, odd pairs in the high half
   function automatic logic [NUM_COND-1:0] eval_conds(input logic [NUM_HITS-1:0] h);
      logic [NUM_COND-1:0] c;
      c = '0;
      for (int i = 0; i < NUM_COND / 2; i++) begin
         c[i] = h[4*i] & h[4*i+1];
         c[i+NUM_COND/2] = h[4*i+2] & h[4*i+3];
      end
      return c;
   endfunction : eval_conds

   // experiment clock active edge as an enable pulse
   logic [TW-1:0] tick_cnt;
   wire tick = (tick_cnt == TICK_LAST);

   always_ff @(posedge SYS_CLK) begin
      if (RST) tick_cnt <= '0;
      else tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
   end

   // hit inputs with test forcing
   wire [NUM_HITS-1:0] test_hits = expand_tests(TEST_BITS);
   wire [NUM_HITS-1:0] eff_hit = HIT_IN | test_hits;
   wire [NUM_COND-1:0] next_cond = eval_conds(eff_hit);

   // registered condition stage, one cycle, well inside the evaluation budget
   logic [NUM_COND-1:0] cond_q;
   logic [NUM_HITS-1:0] hit_q;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cond_q <= '0;
         hit_q <= '0;
      end else begin
         cond_q <= next_cond;
         hit_q <= eff_hit;
      end
   end

   a_cond_eval: assert property (
      ##1 cond_q == $past(next_cond) && EVAL_CYCLES >= 1)
      else $error("condition pattern not settled within evaluation time");

   a_test_force: assert property (
      1'b1 |=> (hit_q & $past(test_hits)) == $past(test_hits))
      else $error("test bit did not force its hit pair");

   // masked trigger decision
   wire [NUM_COND-1:0] masked = cond_q & TRIG_MASK;
   wire next_trigger = |masked;

   always_ff @(posedge SYS_CLK) begin
      if (RST) TRIGGER_OUT <= 1'b0;
      else TRIGGER_OUT <= next_trigger;
   end

   a_trig_or: assert property (
      |(cond_q & TRIG_MASK) |=> TRIGGER_OUT)
      else $error("masked condition did not raise trigger");

   a_mask_gate: assert property (
      (cond_q & TRIG_MASK) == '0 |=> !TRIGGER_OUT)
      else $error("trigger raised by a masked-off condition");

   // pattern latched between clock edges so a short condition still counts
   logic [NUM_COND-1:0] trig_acc;
   wire [NUM_COND-1:0] next_trig_acc = trig_acc | cond_q;

   // timing counter: runs from first condition to the next active edge
   logic tdc_run;
   logic [TDC_W-1:0] tdc_cnt;
   logic [TDC_W-1:0] tdc_code;
   wire any_cond = |cond_q;
   wire sat = (tdc_cnt > TDC_MAX - TDC_STEP);
   wire [TDC_W-1:0] next_tdc_cnt = sat ? TDC_MAX : tdc_cnt + TDC_STEP;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tdc_run <= 1'b0;
         tdc_cnt <= '0;
         trig_acc <= '0;
      end else if (tick) begin
         tdc_run <= 1'b0;
         tdc_cnt <= '0;
         trig_acc <= '0;
      end else begin
         trig_acc <= next_trig_acc;
         if (tdc_run) tdc_cnt <= next_tdc_cnt;
         else if (any_cond) tdc_run <= 1'b1;
      end
   end

   a_tdc_stop: assert property (
      tick |=> !tdc_run && tdc_cnt == '0)
      else $error("timing counter not stopped at active edge");

   a_tdc_start: assert property (
      !tick && !tdc_run && any_cond |=> tdc_run)
      else $error("timing counter missed the first condition");

   a_tdc_count: assert property (
      tdc_run && !tick |=> tdc_cnt == $past(next_tdc_cnt))
      else $error("timing counter did not advance one step");

   a_tdc_idle: assert property (
      !tdc_run && !tick |=> tdc_cnt == $past(tdc_cnt))
      else $error("timing counter moved before it was started");

   a_tdc_limit: assert property (
      tdc_cnt == TDC_MAX && !tick |=> tdc_cnt == TDC_MAX)
      else $error("timing counter wrapped past its top code");

   // a condition shorter than a tick period must still show in the pattern
   a_acc_keep: assert property (
      !tick |=> (trig_acc & $past(cond_q)) == $past(cond_q))
      else $error("short condition lost from the trigger pattern");

   // pipeline shifting: live data on the edge, read-out strobes when halted
   logic strobe_q;
   wire strobe_pulse = READOUT_SHIFT_STROBE && !strobe_q;
   wire shift = PIPELINE_SHIFT_ENABLE ? tick : strobe_pulse;

   always_ff @(posedge SYS_CLK) begin
      if (RST) strobe_q <= 1'b0;
      else strobe_q <= READOUT_SHIFT_STROBE;
   end

   a_live_shift: assert property (
      PIPELINE_SHIFT_ENABLE |-> shift == tick)
      else $error("live pipeline did not follow the active edge");

   // a strobe held high counts as one step; the controller drops it in between
   a_halt_step: assert property (
      !PIPELINE_SHIFT_ENABLE && strobe_q |-> !shift)
      else $error("held strobe gave more than one shift step");

   // four byte pattern word, top byte unused
   wire [PAT_W-1:0] next_pat = {DUMMY_BYTE, next_trig_acc, hit_q};

   logic [PAT_W-1:0] pat_pipe [PIPE_DEPTH];
   logic [TDC_W-1:0] tdc_pipe [PIPE_DEPTH-1];

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         for (int i = 0; i < PIPE_DEPTH; i++) pat_pipe[i] <= '0;
      end else if (shift) begin
         pat_pipe[0] <= next_pat;
         for (int i = 1; i < PIPE_DEPTH; i++) pat_pipe[i] <= pat_pipe[i-1];
      end
   end

   // live mode captures the running count; read-out steps push zeros in
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tdc_code <= '0;
         for (int i = 0; i < PIPE_DEPTH - 1; i++) tdc_pipe[i] <= '0;
      end else if (shift) begin
         tdc_code <= (PIPELINE_SHIFT_ENABLE && tdc_run) ? tdc_cnt : '0;
         tdc_pipe[0] <= tdc_code;
         for (int i = 1; i < PIPE_DEPTH - 1; i++) tdc_pipe[i] <= tdc_pipe[i-1];
      end
   end

   a_pipe_hold: assert property (
      !shift |=> $stable(pat_pipe[PIPE_DEPTH-1]) && $stable(tdc_pipe[PIPE_DEPTH-2]))
      else $error("pipeline moved while halted");

   a_pipe_shift: assert property (
      shift |=> pat_pipe[1] == $past(pat_pipe[0]) && pat_pipe[0] == $past(next_pat))
      else $error("pipeline did not advance on shift");

   a_dummy_byte: assert property (
      pat_pipe[PIPE_DEPTH-1][DUMMY_LSB +: BYTE_W] == DUMMY_BYTE)
      else $error("dummy byte of pattern word not zero");

   a_tdc_pipe: assert property (
      shift |=> tdc_pipe[0] == $past(tdc_code))
      else $error("timing code did not enter its pipeline");

   a_halt_zero: assert property (
      shift && !PIPELINE_SHIFT_ENABLE |=> tdc_code == '0)
      else $error("read-out step did not clear the timing stage");

   a_hit_store: assert property (
      shift |=> pat_pipe[0][HIT_LSB +: NUM_HITS] == $past(hit_q))
      else $error("hit pattern not stored with its trigger pattern");

   // read-out byte selection at the pipeline ends
   wire [PAT_W-1:0] pat_out = pat_pipe[PIPE_DEPTH-1];
   wire [TDC_W-1:0] tdc_out = tdc_pipe[PIPE_DEPTH-2];
   wire [ADDR_W-1:0] rel_addr = BP_ADDR - BOARD_BASE;
   wire addr_hit = (BP_ADDR >= BOARD_BASE) && (rel_addr < ADDR_W'(NUM_LOC));
   wire [BYTE_W-1:0] sel_byte;

   assign sel_byte = (rel_addr == LOC_ID) ? BOARD_ID :
      (rel_addr == LOC_HIT_LO) ? pat_out[HIT_LSB +: BYTE_W] :
      (rel_addr == LOC_HIT_HI) ? pat_out[HIT_LSB + BYTE_W +: BYTE_W] :
      (rel_addr == LOC_TRIG) ? pat_out[TRIG_LSB +: BYTE_W] :
      (rel_addr == LOC_DUMMY) ? pat_out[DUMMY_LSB +: BYTE_W] :
      {{(BYTE_W - TDC_W){1'b0}}, tdc_out};

   // requests to other boards are acknowledged and dropped
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [BYTE_W-1:0] fifo_out_data;
   wire push_req = BP_RD_VALID && addr_hit;

   assign BP_RD_READY = addr_hit ? fifo_in_ready : 1'b1;

   event_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_read_fifo (
      .clk(SYS_CLK),
      .rst(RST),
      .in_valid(push_req),
      .in_ready(fifo_in_ready),
      .in_data(sel_byte),
      .out_valid(fifo_out_valid),
      .out_ready(BP_DATA_ACK),
      .out_data(fifo_out_data)
   );

   assign BP_DATA_OUT = fifo_out_data;
   assign BP_DATA_VALID = fifo_out_valid;
   assign BP_DATA_OE = fifo_out_valid && addr_hit;

   a_bus_release: assert property (
      !addr_hit |-> !BP_DATA_OE)
      else $error("data bus driven for a foreign address");

   a_oe_valid: assert property (
      BP_DATA_OE |-> BP_DATA_VALID)
      else $error("data bus driven with no byte to show");

   a_full_refuse: assert property (
      addr_hit && !fifo_in_ready |-> !BP_RD_READY)
      else $error("read taken while the byte queue was full");

   a_foreign_drop: assert property (
      !addr_hit |-> BP_RD_READY)
      else $error("foreign read request was held off");

   a_id_read: assert property (
      push_req && fifo_in_ready && rel_addr == LOC_ID && !fifo_out_valid
      |=> BP_DATA_OUT == BOARD_ID && BP_DATA_VALID)
      else $error("board id byte not returned");

   a_tdc_byte: assert property (
      push_req && fifo_in_ready && rel_addr == LOC_TDC && !fifo_out_valid
      |=> BP_DATA_OUT == {{(BYTE_W - TDC_W){1'b0}}, $past(tdc_out)})
      else $error("timing byte not returned");
endmodule : trigger_pipeline

// >>> test/readout_ctrl_model.sv
`timescale 1ns/10ps
module readout_ctrl_model
   import trig_pkg::*;
#(
   parameter logic [ADDR_W-1:0] BASE = 9'h100
) (
   // clock
   input wire logic clk,
   // backplane read side
   output logic [ADDR_W-1:0] addr,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic strobe,
   output logic ack
);
   logic [BYTE_W-1:0] notes[$];
   logic stall = 1'b0;
   logic refused = 1'b0;
   initial begin
      addr = 9'h1ff;
      rd_valid = 1'b0;
      strobe = 1'b0;
   end
   // ack held low while stalled so the fifo can fill up
   assign ack = !stall;
   // request held until ready is seen high at a falling edge
   task automatic read_byte(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] e);
      logic r;
      int n;
      logic [ADDR_W-1:0] off;
      n = 0;
      off = a - BASE;
      addr = a;
      rd_valid = 1'b1;
      do begin
         @(negedge clk);
         r = rd_ready;
         if (!r) refused = 1'b1;
         @(posedge clk);
         n++;
      end while (!r && n < 200);
      if (off < NUM_LOC) notes.push_back(e);
      #1;
   endtask : read_byte
   // valid stays high between bytes, so reads run back to back
   task automatic readout(input int steps, input logic [8*NUM_LOC-1:0] e, input int times);
      for (int s = 0; s < steps; s++) begin
         strobe = 1'b1;
         @(posedge clk);
         #1;
         strobe = 1'b0;
         @(posedge clk);
         #1;
      end
      for (int t = 0; t < times; t++) begin
         for (int j = 0; j < NUM_LOC; j++) begin
            read_byte(BASE + ADDR_W'(j), e[8*j+:8]);
            if (j == 2) read_byte(BASE + ADDR_W'(NUM_LOC), 8'h00);
         end
      end
      rd_valid = 1'b0;
   endtask : readout
endmodule : readout_ctrl_model

// >>> test/trigger_pipeline_tb_top.sv
`timescale 1ns/10ps
module trigger_pipeline_tb_top
   import trig_pkg::*;
   ;
   localparam int DEPTH = 4;
   localparam int TICK = 4;
   // identification value is arbitrary
   localparam logic [BYTE_W-1:0] ID = 8'h3c;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic [NUM_HITS-1:0] HIT_IN = 16'h0000;
   logic [NUM_COND-1:0] TEST_BITS = 8'h00;
   logic [NUM_COND-1:0] TRIG_MASK = 8'h00;
   logic PIPELINE_SHIFT_ENABLE = 1'b0;
   logic READOUT_SHIFT_STROBE, TRIGGER_OUT, BP_RD_VALID, BP_RD_READY;
   logic BP_DATA_OE, BP_DATA_VALID, BP_DATA_ACK;
   logic [ADDR_W-1:0] BP_ADDR;
   logic [BYTE_W-1:0] BP_DATA_OUT, e;
   int fail_count = 0;
   int num_checks = 0;

   always #5 SYS_CLK = ~SYS_CLK;

   trigger_pipeline #(.PIPE_DEPTH(DEPTH), .TICK_DIV(TICK), .FIFO_DEPTH(8),
      .BOARD_BASE(9'h100), .BOARD_ID(ID)) u_trigger_pipeline (
      .SYS_CLK(SYS_CLK), .RST(RST), .HIT_IN(HIT_IN), .TEST_BITS(TEST_BITS),
      .TRIG_MASK(TRIG_MASK), .PIPELINE_SHIFT_ENABLE(PIPELINE_SHIFT_ENABLE),
      .READOUT_SHIFT_STROBE(READOUT_SHIFT_STROBE), .TRIGGER_OUT(TRIGGER_OUT),
      .BP_ADDR(BP_ADDR), .BP_RD_VALID(BP_RD_VALID), .BP_RD_READY(BP_RD_READY),
      .BP_DATA_OUT(BP_DATA_OUT), .BP_DATA_OE(BP_DATA_OE),
      .BP_DATA_VALID(BP_DATA_VALID), .BP_DATA_ACK(BP_DATA_ACK));

   readout_ctrl_model #(.BASE(9'h100)) u_readout_ctrl_model (.clk(SYS_CLK),
      .addr(BP_ADDR), .rd_valid(BP_RD_VALID), .rd_ready(BP_RD_READY),
      .strobe(READOUT_SHIFT_STROBE), .ack(BP_DATA_ACK));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic logic [15:0] forced(input logic [15:0] h, input logic [7:0] t);
      for (int i = 0; i < 8; i++) h[2*i+:2] = h[2*i+:2] | {2{t[i]}};
      return h;
   endfunction : forced

   function automatic logic [7:0] conds(input logic [15:0] x);
      logic [7:0] c;
      for (int i = 0; i < 4; i++) begin
         c[i] = x[4*i] & x[4*i+1];
         c[i+4] = x[4*i+2] & x[4*i+3];
      end
      return c;
   endfunction : conds

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // takes the oldest note whenever a byte is handed over
   always @(posedge SYS_CLK) begin
      if (RST === 1'b0) begin
         check("data_oe", {7'h0, BP_DATA_VALID && BP_ADDR >= 9'h100 && BP_ADDR < 9'h106},
            {7'h0, BP_DATA_OE});
         if (BP_DATA_VALID === 1'b1 && BP_DATA_ACK === 1'b1) begin
            e = (u_readout_ctrl_model.notes.size() > 0) ?
               u_readout_ctrl_model.notes.pop_front() : ~BP_DATA_OUT;
            check("bp_data", e, BP_DATA_OUT);
         end
      end
   end

   initial begin
      #50000;
      fail_count++;
      give_verdict();
   end

   initial begin
      logic [15:0] hv;
      logic [7:0] te;
      void'($urandom(32'hc3ccc4f9));
      repeat (8) @(posedge SYS_CLK);
      #1;
      RST = 1'b0;
      @(posedge SYS_CLK);
      #1;
      check("idle_state", 8'h01, {5'h0, TRIGGER_OUT, BP_DATA_VALID, BP_RD_READY});
      for (int k = 0; k < 4; k++) begin
         HIT_IN = (k == 0) ? 16'h0000 : 16'($urandom);
         TEST_BITS = (k == 1) ? 8'h00 : 8'($urandom) | {7'h0, k == 3};
         TRIG_MASK = (k == 3) ? 8'hff : 8'($urandom);
         hv = forced(HIT_IN, TEST_BITS);
         // last pass reads the live pipe end with no steps, so the running count shows
         te = (k == 3) ? 8'(TDC_STEP * (TICK - 2)) : 8'h00;
         PIPELINE_SHIFT_ENABLE = 1'b1;
         repeat (10 * TICK * DEPTH) @(posedge SYS_CLK);
         #1;
         check("trigger_out", {7'h0, |(conds(hv) & TRIG_MASK)}, {7'h0, TRIGGER_OUT});
         PIPELINE_SHIFT_ENABLE = 1'b0;
         u_readout_ctrl_model.stall = (k == 2);
         @(posedge SYS_CLK);
         #1;
         // halted pipe must ignore the hit change made twelve cycles after the read-out starts
         fork
            u_readout_ctrl_model.readout((k == 3) ? 0 : DEPTH, {te, 8'h00, conds(hv), hv, ID},
               (k == 2) ? 2 : 1);
            begin
               repeat (12) @(posedge SYS_CLK);
               #1;
               HIT_IN = ~HIT_IN;
               repeat (18) @(posedge SYS_CLK);
               #1;
               u_readout_ctrl_model.stall = 1'b0;
            end
         join
         for (int n = 0; n < 100 && u_readout_ctrl_model.notes.size() > 0; n++)
            @(posedge SYS_CLK);
         #1;
         check("notes_left", 8'h00, 8'(u_readout_ctrl_model.notes.size()));
      end
      check("refused", 8'h01, {7'h0, u_readout_ctrl_model.refused});
      give_verdict();
   end
endmodule : trigger_pipeline_tb_top
